// *** motion_image_readout_regs.sv ***
// Read-side register set of an optical motion sensor behind a four-wire
// serial port. Assumes motion deltas, feature counts and a pixel stream
// arrive from the imaging core on mclk; serial pins and fault are async.
`timescale 1ns/1ns
`include "motion_image_readout_defs.svh"

module motion_image_readout_regs #(
  parameter int PIXELS = 484
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic serialSelectN,
  input wire logic serialClk,
  input wire logic serialDataIn,
  output logic serialDataOut,
  output logic serialDataOutOe,
  input wire logic motionValid,
  input wire logic [7:0] motionDx,
  input wire logic [7:0] motionDy,
  input wire logic [8:0] featureCount,
  input wire logic pixValid,
  input wire logic [7:0] pixData,
  input wire logic pixLast,
  input wire logic [7:0] laserCtrl0,
  input wire logic [7:0] laserCtrl1,
  input wire logic [7:0] laserPower0,
  input wire logic [7:0] laserPower1,
  input wire logic emitterFaultRaw,
  input wire logic [7:0] selftestResult0,
  input wire logic [7:0] selftestResult1,
  output logic [15:0] exposureCycles
);

  localparam int PW = (PIXELS > 1) ? $clog2(PIXELS) : 1;
  localparam logic [PW-1:0] LAST_PIXEL = PW'(PIXELS - 1);

  // Pin synchronisation; select idles high so reset keeps the port closed
  logic [3:0] pinSync;
  pin_synchronizer #(.WIDTH(4), .RESET_VALUE(4'b0110)) i_pin_synchronizer (
    .mclk(mclk),
    .rst(rst),
    .async({emitterFaultRaw, serialSelectN, serialClk, serialDataIn}),
    .synced(pinSync)
  );
  wire faultS = pinSync[3];
  wire selectNS = pinSync[2];
  wire sclkS = pinSync[1];
  wire mosiS = pinSync[0];

  // Serial port
  motion_image_readout_pkg::serial_state_t serState_reg;
  logic sclkPrev_reg;
  logic [2:0] bitCnt_reg;
  logic [6:0] shiftIn_reg;
  logic [6:0] addr_reg;
  logic [7:0] txShift_reg;
  logic [7:0] readData;

  wire active = ~selectNS;
  wire sclkRise = active & sclkS & ~sclkPrev_reg;
  wire sclkFall = active & ~sclkS & sclkPrev_reg;
  wire [7:0] rxByte = {shiftIn_reg, mosiS};
  wire byteDone = sclkRise && (bitCnt_reg == 3'd7);
  wire inAddr = serState_reg == motion_image_readout_pkg::SER_ADDR;
  wire rdStrobe = byteDone && inAddr && !rxByte[`MIR_SERIAL_WRITE_BIT];
  wire [6:0] rdAddr = rxByte[6:0];
  wire wrStrobe = byteDone && serState_reg == motion_image_readout_pkg::SER_WDATA;

  always_ff @(posedge mclk) begin
    if (rst) begin
      serState_reg <= motion_image_readout_pkg::SER_ADDR;
      sclkPrev_reg <= 1'b1;
      bitCnt_reg <= 3'd0;
      shiftIn_reg <= 7'h00;
      addr_reg <= 7'h00;
      txShift_reg <= 8'h00;
      serialDataOut <= 1'b0;
    end else begin
      sclkPrev_reg <= sclkS;
      if (!active) begin
        serState_reg <= motion_image_readout_pkg::SER_ADDR;
        bitCnt_reg <= 3'd0;
      end else begin
        if (sclkRise) begin
          bitCnt_reg <= bitCnt_reg + 3'd1;
          shiftIn_reg <= rxByte[6:0];
        end
        if (sclkFall && serState_reg == motion_image_readout_pkg::SER_RDATA) begin
          serialDataOut <= txShift_reg[7];
          txShift_reg <= {txShift_reg[6:0], 1'b0};
        end
        if (byteDone) begin
          unique case (serState_reg)
            motion_image_readout_pkg::SER_ADDR: begin
              addr_reg <= rxByte[6:0];
              txShift_reg <= readData;
              serState_reg <= rxByte[`MIR_SERIAL_WRITE_BIT] ?
                motion_image_readout_pkg::SER_WDATA : motion_image_readout_pkg::SER_RDATA;
            end
            motion_image_readout_pkg::SER_WDATA,
            motion_image_readout_pkg::SER_RDATA: begin
              serState_reg <= motion_image_readout_pkg::SER_ADDR;
            end
          endcase
        end
      end
    end
  end

  assign serialDataOutOe = active;

  // Access decode
  wire statusWr = wrStrobe && addr_reg == `MIR_ADDR_STATUS;
  wire dumpWr = wrStrobe && addr_reg == `MIR_ADDR_DUMP;
  wire xRead = rdStrobe && rdAddr == `MIR_ADDR_XCOUNT;
  wire yRead = rdStrobe && rdAddr == `MIR_ADDR_YCOUNT;
  wire expHighRead = rdStrobe && rdAddr == `MIR_ADDR_EXP_HIGH;
  wire expLowRead = rdStrobe && rdAddr == `MIR_ADDR_EXP_LOW;
  wire dumpRead = rdStrobe && rdAddr == `MIR_ADDR_DUMP;

  // Movement counters; a read or status write clears, fresh motion still lands
  logic [7:0] xCount_reg;
  logic [7:0] yCount_reg;
  logic moveFlag_reg;
  logic overflow_reg;

  wire [7:0] xBase = (xRead || statusWr) ? `MIR_RST_COUNT : xCount_reg;
  wire [7:0] yBase = (yRead || statusWr) ? `MIR_RST_COUNT : yCount_reg;
  wire [7:0] dxIn = motionValid ? motionDx : 8'h00;
  wire [7:0] dyIn = motionValid ? motionDy : 8'h00;
  wire [8:0] xSum = {xBase[7], xBase} + {dxIn[7], dxIn};
  wire [8:0] ySum = {yBase[7], yBase} + {dyIn[7], dyIn};
  wire xOverflow = xSum[8] ^ xSum[7];
  wire yOverflow = ySum[8] ^ ySum[7];
  // Saturate so the reported direction survives an overflow
  wire [7:0] xNext = xOverflow ? (xSum[8] ? 8'h80 : 8'h7f) : xSum[7:0];
  wire [7:0] yNext = yOverflow ? (ySum[8] ? 8'h80 : 8'h7f) : ySum[7:0];
  wire moveEvent = (dxIn != 8'h00) || (dyIn != 8'h00);
  wire moveClear = statusWr || ((xRead || yRead) && xNext == 8'h00 && yNext == 8'h00);
  wire moveFlag_next = moveEvent || (moveFlag_reg && !moveClear);
  wire overflow_next = xOverflow || yOverflow || (overflow_reg && !statusWr);

  always_ff @(posedge mclk) begin
    if (rst) begin
      xCount_reg <= `MIR_RST_COUNT;
      yCount_reg <= `MIR_RST_COUNT;
      moveFlag_reg <= 1'b0;
      overflow_reg <= 1'b0;
    end else begin
      xCount_reg <= xNext;
      yCount_reg <= yNext;
      moveFlag_reg <= moveFlag_next;
      overflow_reg <= overflow_next;
    end
  end

  // Frame statistics
  logic [PW-1:0] pixCnt_reg;
  logic [7:0] runMax_reg;
  logic [7:0] runMin_reg;
  logic [16:0] runSum_reg;
  logic [7:0] brightest_reg;
  logic [7:0] darkest_reg;
  logic [7:0] brightSum_reg;
  logic [7:0] surface_reg;
  logic [15:0] exposure_reg;

  wire firstPix = pixCnt_reg == '0;
  wire [7:0] pixClamped = (pixData > `MIR_PIXEL_CLAMP) ? `MIR_PIXEL_CLAMP : pixData;
  wire [7:0] newMax = (firstPix || pixClamped > runMax_reg) ? pixClamped : runMax_reg;
  wire [7:0] newMin = (firstPix || pixClamped < runMin_reg) ? pixClamped : runMin_reg;
  wire [16:0] newSum = (firstPix ? 17'h00000 : runSum_reg) + {9'h000, pixData};
  wire frameEnd = pixValid && pixLast;
  wire [7:0] sumHigh = newSum[16:`MIR_SUM_SHIFT];
  wire [7:0] surfaceRaw = featureCount[8:1];
  wire [7:0] surfaceCapped = (surfaceRaw > `MIR_SURFACE_MAX) ?
    `MIR_SURFACE_MAX : surfaceRaw;
  wire tooBright = newMax > `MIR_BRIGHT_HIGH || sumHigh > `MIR_SUM_HIGH;
  wire tooDark = newMax < `MIR_BRIGHT_LOW && sumHigh < `MIR_SUM_LOW;
  wire [15:0] expDown = (exposure_reg > `MIR_EXP_MIN + `MIR_EXP_STEP) ?
    exposure_reg - `MIR_EXP_STEP : `MIR_EXP_MIN;
  wire [15:0] expUp = (exposure_reg < `MIR_EXP_MAX - `MIR_EXP_STEP) ?
    exposure_reg + `MIR_EXP_STEP : `MIR_EXP_MAX;
  wire [15:0] exposure_next = tooBright ? expDown : (tooDark ? expUp : exposure_reg);

  always_ff @(posedge mclk) begin
    if (rst) begin
      pixCnt_reg <= '0;
      runMax_reg <= 8'h00;
      runMin_reg <= 8'h00;
      runSum_reg <= 17'h00000;
      brightest_reg <= `MIR_RST_BRIGHTEST;
      darkest_reg <= `MIR_RST_DARKEST;
      brightSum_reg <= `MIR_RST_BRIGHT_SUM;
      surface_reg <= `MIR_RST_SURFACE;
      exposure_reg <= `MIR_RST_EXPOSURE;
    end else if (pixValid) begin
      runMax_reg <= newMax;
      runMin_reg <= newMin;
      runSum_reg <= newSum;
      pixCnt_reg <= (pixLast || pixCnt_reg == LAST_PIXEL) ? '0 : pixCnt_reg + PW'(1);
      if (pixLast) begin
        brightest_reg <= newMax;
        darkest_reg <= newMin;
        brightSum_reg <= sumHigh;
        surface_reg <= surfaceCapped;
        exposure_reg <= exposure_next;
      end
    end
  end

  assign exposureCycles = exposure_reg;

  // Exposure low byte is frozen when the high byte is read
  logic [7:0] expLowShadow_reg;
  logic expPending_reg;

  always_ff @(posedge mclk) begin
    if (rst) begin
      expLowShadow_reg <= 8'(`MIR_RST_EXPOSURE);
      expPending_reg <= 1'b0;
    end else begin
      if (expHighRead) begin
        expLowShadow_reg <= exposure_reg[7:0];
      end
      expPending_reg <= expHighRead || (expPending_reg && !expLowRead);
    end
  end

  // Pixel dump: one capture per frame, held until read or a dump write
  logic [PW-1:0] dumpPtr_reg;
  logic [7:0] dumpData_reg;
  logic imgReady_reg;
  logic origin_reg;
  logic taken_reg;

  wire capture = pixValid && pixCnt_reg == dumpPtr_reg && !imgReady_reg
    && !taken_reg && !dumpWr;
  wire ptrWrap = dumpRead && dumpPtr_reg == LAST_PIXEL;
  wire imgReady_next = capture || (imgReady_reg && !dumpRead && !dumpWr);
  wire origin_next = dumpWr || ptrWrap || (origin_reg && !dumpRead);

  always_ff @(posedge mclk) begin
    if (rst) begin
      dumpPtr_reg <= '0;
      dumpData_reg <= `MIR_RST_DUMP;
      imgReady_reg <= 1'b0;
      origin_reg <= 1'b0;
      taken_reg <= 1'b0;
    end else begin
      imgReady_reg <= imgReady_next;
      origin_reg <= origin_next;
      taken_reg <= frameEnd ? 1'b0 : (taken_reg || capture);
      if (capture) begin
        dumpData_reg <= pixData;
      end
      if (dumpWr) begin
        dumpPtr_reg <= '0;
      end else if (dumpRead) begin
        dumpPtr_reg <= ptrWrap ? '0 : dumpPtr_reg + PW'(1);
      end
    end
  end

  // Status byte
  wire laserValid = (laserCtrl0[7] == ~laserCtrl1[7]) && (laserCtrl0[5] == ~laserCtrl1[5])
    && (laserPower0 == ~laserPower1);
  logic [7:0] statusByte;
  always_comb begin
    statusByte = 8'h00;
    statusByte[`MIR_BIT_MOVEMENT] = moveFlag_reg;
    statusByte[`MIR_BIT_IMG_READY] = imgReady_reg;
    statusByte[`MIR_BIT_ORIGIN] = origin_reg;
    statusByte[`MIR_BIT_OVERFLOW] = overflow_reg;
    statusByte[`MIR_BIT_LASER_VALID] = laserValid;
    statusByte[`MIR_BIT_FAULT] = faultS;
  end

  always_comb begin
    unique case (rdAddr)
      `MIR_ADDR_STATUS: readData = statusByte;
      `MIR_ADDR_XCOUNT: readData = xCount_reg;
      `MIR_ADDR_YCOUNT: readData = yCount_reg;
      `MIR_ADDR_SURFACE: readData = surface_reg;
      `MIR_ADDR_EXP_HIGH: readData = exposure_reg[15:8];
      `MIR_ADDR_EXP_LOW: readData = expPending_reg ? expLowShadow_reg : exposure_reg[7:0];
      `MIR_ADDR_BRIGHTEST: readData = brightest_reg;
      `MIR_ADDR_BRIGHT_SUM: readData = brightSum_reg;
      `MIR_ADDR_DARKEST: readData = darkest_reg;
      `MIR_ADDR_DUMP: readData = dumpData_reg;
      `MIR_ADDR_SELFTEST0: readData = selftestResult0;
      `MIR_ADDR_SELFTEST1: readData = selftestResult1;
      default: readData = 8'h00;
    endcase
  end

endmodule

// *** motion_image_readout_defs.svh ***
// Register offsets, status bit positions, reset values and tuning constants
// for the motion and image readout register set. Definitions only.
`ifndef MOTION_IMAGE_READOUT_DEFS_SVH
`define MOTION_IMAGE_READOUT_DEFS_SVH

`define MIR_ADDR_STATUS 7'h02
`define MIR_ADDR_XCOUNT 7'h03
`define MIR_ADDR_YCOUNT 7'h04
`define MIR_ADDR_SURFACE 7'h05
`define MIR_ADDR_EXP_HIGH 7'h06
`define MIR_ADDR_EXP_LOW 7'h07
`define MIR_ADDR_BRIGHTEST 7'h08
`define MIR_ADDR_BRIGHT_SUM 7'h09
`define MIR_ADDR_DARKEST 7'h0a
`define MIR_ADDR_DUMP 7'h0b
`define MIR_ADDR_SELFTEST0 7'h0c
`define MIR_ADDR_SELFTEST1 7'h0d

`define MIR_BIT_MOVEMENT 7
`define MIR_BIT_IMG_READY 6
`define MIR_BIT_ORIGIN 5
`define MIR_BIT_OVERFLOW 4
`define MIR_BIT_LASER_VALID 3
`define MIR_BIT_FAULT 2
`define MIR_SERIAL_WRITE_BIT 7

`define MIR_RST_COUNT 8'h00
`define MIR_RST_SURFACE 8'h00
`define MIR_RST_EXPOSURE 16'h0064
`define MIR_RST_BRIGHTEST 8'hd0
`define MIR_RST_BRIGHT_SUM 8'h80
`define MIR_RST_DARKEST 8'h00
`define MIR_RST_DUMP 8'h00

`define MIR_PIXEL_CLAMP 8'hfe
`define MIR_SURFACE_MAX 8'ha2
`define MIR_SUM_SHIFT 9
`define MIR_EXP_MIN 16'h0010
`define MIR_EXP_MAX 16'hfff0
`define MIR_EXP_STEP 16'h0004
`define MIR_BRIGHT_HIGH 8'hc8
`define MIR_BRIGHT_LOW 8'h60
`define MIR_SUM_HIGH 8'hb4
`define MIR_SUM_LOW 8'h30

`endif

// *** motion_image_readout_pkg.sv ***
// Types shared by the readout register set.
// Constants live in motion_image_readout_defs.svh.
package motion_image_readout_pkg;

  typedef enum logic [1:0] {
    SER_ADDR,
    SER_WDATA,
    SER_RDATA
  } serial_state_t;

endpackage

// *** pin_synchronizer.sv ***
// Two-flop synchroniser for a group of independent level inputs.
// Assumes each bit is a slow level; no bus coherence across bits.
`timescale 1ns/1ns

module pin_synchronizer #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async,
  output logic [WIDTH-1:0] synced
);

  logic [WIDTH-1:0] stage1_reg;

  always_ff @(posedge mclk) begin
    if (rst) begin
      stage1_reg <= RESET_VALUE;
      synced <= RESET_VALUE;
    end else begin
      stage1_reg <= async;
      synced <= stage1_reg;
    end
  end

endmodule

// *** motion_image_readout_monitor.sv ***
// Port-level checker for the motion and image readout register set.
// Assumes one mclk domain with synchronous active-high rst.
`timescale 1ns/1ns
module motion_image_readout_monitor (
  input wire logic mclk,
  input wire logic rst,
  input wire logic serialSelectN,
  input wire logic serialClk,
  input wire logic serialDataOut,
  input wire logic serialDataOutOe,
  input wire logic pixValid,
  input wire logic pixLast,
  input wire logic [15:0] exposureCycles
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  logic frameEnd;
  assign frameEnd = pixValid && pixLast;
  // Two sync flops plus margin before the enable may follow select
  sequence s_selected;
    !serialSelectN [*3];
  endsequence
  sequence s_deselected;
    serialSelectN [*3];
  endsequence
  property p_oe_on;
    s_selected |=> serialDataOutOe;
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("enable low while selected");
  property p_oe_off;
    s_deselected |=> !serialDataOutOe;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("enable high while deselected");
  property p_reset_pins;
    $fell(rst) |-> !serialDataOutOe && !serialDataOut;
  endproperty
  a_reset_pins: assert property (p_reset_pins) else $error("serial pins not idle at reset");
  property p_reset_exposure;
    $fell(rst) |-> exposureCycles == 16'h0064;
  endproperty
  a_reset_exposure: assert property (p_reset_exposure) else $error("exposure reset");
  property p_exp_step;
    $changed(exposureCycles) && !$past(rst) |->
      16'(exposureCycles - $past(exposureCycles)) inside {16'h0004, 16'hfffc};
  endproperty
  a_exp_step: assert property (p_exp_step) else $error("exposure step size");
  property p_exp_frame;
    $changed(exposureCycles) && !$past(rst) |->
      $past(frameEnd, 1) || $past(frameEnd, 2) || $past(frameEnd, 3);
  endproperty
  a_exp_frame: assert property (p_exp_frame) else $error("exposure moved mid frame");
  property p_exp_limits;
    exposureCycles >= 16'h0010 && exposureCycles <= 16'hfff0;
  endproperty
  a_exp_limits: assert property (p_exp_limits) else $error("exposure out of range");
  // Read data may only move after a falling serial clock
  property p_dout_after_fall;
    $changed(serialDataOut) && !serialSelectN && !$past(serialSelectN, 4) |->
      !$past(serialClk, 2) || !$past(serialClk, 3) || !$past(serialClk, 4);
  endproperty
  a_dout_after_fall: assert property (p_dout_after_fall) else $error("data out moved early");
endmodule
bind motion_image_readout_regs motion_image_readout_monitor i_motion_image_readout_monitor (
  .mclk, .rst, .serialSelectN, .serialClk, .serialDataOut, .serialDataOutOe, .pixValid,
  .pixLast, .exposureCycles);

// *** host_serial_model.sv ***
// Host microcontroller model: drives select, serial clock and data in.
// Assumes the device answers MSB first; clock idles high between frames.
`timescale 1ns/1ns
module host_serial_model (
  output logic selectN,
  output logic linkClk,
  output logic toDevice,
  input wire logic fromDevice
);
  initial begin
    selectN = 1'b1;
    linkClk = 1'b1;
    toDevice = 1'b1;
  end
  task automatic xfer(input logic [15:0] tx, output logic [7:0] rx);
    #3 selectN = 1'b0;
    #80;
    for (int i = 15; i >= 0; i--) begin
      linkClk = 1'b0;
      toDevice = tx[i];
      #80 linkClk = 1'b1;
      if (i < 8) begin
        rx[i] = fromDevice;
      end
      #80;
    end
    // Released line shows the inverse, not a stale bit
    toDevice = ~toDevice;
    selectN = 1'b1;
    #160;
  endtask
endmodule

// *** test_motion_image_readout_regs.sv ***
// Self-checking bench for the motion and image readout register set.
// Assumes the host model owns the serial pins; array shrunk to 8 pixels.
`timescale 1ns/1ns
module test_motion_image_readout_regs;
  localparam int PIX = 8;
  localparam logic [7:0] RESET_VALS [11] = '{8'h08, 8'h00, 8'h00, 8'h00, 8'h00, 8'h64,
    8'hd0, 8'h80, 8'h00, 8'h00, 8'h9c};
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic serialSelectN, serialClk, serialDataIn, serialDataOut, serialDataOutOe;
  logic motionValid = 1'b0;
  logic [7:0] motionDx = 8'h00;
  logic [7:0] motionDy = 8'h00;
  logic [8:0] featureCount = 9'h000;
  logic pixValid = 1'b0;
  logic pixLast = 1'b0;
  logic [7:0] pixData = 8'h00;
  logic [7:0] laserCtrl0 = 8'h00;
  logic [7:0] laserCtrl1 = 8'ha0;
  logic [7:0] laserPower0 = 8'h3c;
  logic [7:0] laserPower1 = 8'hc3;
  logic emitterFaultRaw = 1'b0;
  logic [15:0] exposureCycles;
  int bad_count = 0;
  int n_tests = 0;
  always #10 mclk = ~mclk;
  // Undriven data line shows the inverse so a stale bit cannot pass
  wire misoLine = serialDataOutOe ? serialDataOut : ~serialDataOut;
  motion_image_readout_regs #(.PIXELS(PIX)) i_motion_image_readout_regs (
    .mclk, .rst, .serialSelectN, .serialClk, .serialDataIn, .serialDataOut, .serialDataOutOe,
    .motionValid, .motionDx, .motionDy, .featureCount, .pixValid, .pixData, .pixLast,
    .laserCtrl0, .laserCtrl1, .laserPower0, .laserPower1, .emitterFaultRaw,
    .selftestResult0(8'h9c), .selftestResult1(8'h5e), .exposureCycles);
  host_serial_model i_host_serial_model (.selectN(serialSelectN), .linkClk(serialClk),
    .toDevice(serialDataIn), .fromDevice(misoLine));
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rreg(input logic [6:0] a, input logic [7:0] exp, input string what);
    logic [7:0] got;
    @(negedge mclk);
    i_host_serial_model.xfer({1'b0, a, 8'h5a}, got);
    chk(what, {8'h00, exp}, {8'h00, got});
  endtask
  task automatic wreg(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] got;
    @(negedge mclk);
    i_host_serial_model.xfer({1'b1, a, d}, got);
  endtask
  task automatic move(input logic [7:0] dx, input logic [7:0] dy);
    @(negedge mclk);
    motionValid = 1'b1;
    motionDx = dx;
    motionDy = dy;
    @(negedge mclk);
    motionValid = 1'b0;
  endtask
  task automatic frame(input logic [7:0] base, input logic [7:0] stepv, input logic [8:0] f);
    featureCount = f;
    for (int i = 0; i < PIX; i++) begin
      @(negedge mclk);
      pixValid = 1'b1;
      pixData = 8'(base + stepv * i);
      pixLast = (i == PIX - 1);
    end
    @(negedge mclk);
    pixValid = 1'b0;
    pixLast = 1'b0;
    repeat (4) @(negedge mclk);
  endtask
  task automatic t_reset;
    // Exposure high then low back to back keeps the pair coherent
    for (int i = 0; i < 11; i++) begin
      rreg(7'(2 + i), RESET_VALS[i], "reset value");
    end
    rreg(7'h0d, 8'h5e, "selftest byte 1");
    rreg(7'h30, 8'h00, "unmapped");
    chk("exposure port", 16'h0064, exposureCycles);
  endtask
  task automatic t_motion;
    move(8'h05, 8'hfd);
    rreg(7'h02, 8'h88, "status moved");
    rreg(7'h03, 8'h05, "x count");
    rreg(7'h04, 8'hfd, "y count");
    rreg(7'h03, 8'h00, "x after read");
    rreg(7'h02, 8'h08, "status reported");
    move(8'h7f, 8'h80);
    move(8'h7f, 8'h80);
    rreg(7'h02, 8'h98, "status overflow");
    rreg(7'h04, 8'h80, "y saturated");
    wreg(7'h02, 8'hff);
    rreg(7'h02, 8'h08, "status cleared");
    rreg(7'h03, 8'h00, "x cleared");
  endtask
  task automatic t_laser;
    @(negedge mclk);
    laserPower1 = 8'h3d;
    rreg(7'h02, 8'h00, "power pair");
    @(negedge mclk);
    laserPower1 = 8'hc3;
    laserCtrl1 = 8'h20;
    rreg(7'h02, 8'h00, "ctrl pair");
    @(negedge mclk);
    laserCtrl1 = 8'ha0;
    emitterFaultRaw = 1'b1;
    rreg(7'h02, 8'h0c, "fault");
    @(negedge mclk);
    emitterFaultRaw = 1'b0;
    rreg(7'h02, 8'h08, "no fault");
  endtask
  task automatic t_stats;
    frame(8'hff, 8'h00, 9'h1ff);
    rreg(7'h08, 8'hfe, "brightest clamp");
    rreg(7'h0a, 8'hfe, "darkest clamp");
    rreg(7'h09, 8'h03, "sum");
    rreg(7'h05, 8'ha2, "surface cap");
    chk("exposure down", 16'h0060, exposureCycles);
    frame(8'h20, 8'h08, 9'h0c8);
    rreg(7'h08, 8'h58, "brightest");
    rreg(7'h0a, 8'h20, "darkest");
    rreg(7'h05, 8'h64, "surface");
    rreg(7'h06, 8'h00, "exposure high");
    rreg(7'h07, 8'h64, "exposure low");
    chk("exposure up", 16'h0064, exposureCycles);
  endtask
  task automatic t_dump;
    logic [7:0] e;
    wreg(7'h0b, 8'h3c);
    rreg(7'h02, 8'h28, "status after grab");
    frame(8'h10, 8'h01, 9'h000);
    // Second frame must not replace an unread byte
    frame(8'h20, 8'h01, 9'h000);
    e = 8'h10;
    for (int i = 0; i < PIX; i++) begin
      rreg(7'h02, {2'b01, i == 0, 5'h08}, "status ready");
      rreg(7'h0b, e, "dump byte");
      rreg(7'h02, {2'b00, i == PIX - 1, 5'h08}, "status drained");
      frame(8'(8'h40 + 16 * i), 8'h01, 9'h000);
      e = 8'(8'h40 + 16 * i + (i + 1) % PIX);
    end
    rreg(7'h0b, e, "dump wrapped");
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(negedge mclk);
    rst = 1'b0;
    repeat (4) @(negedge mclk);
    t_reset();
    $display("reset test done");
    t_motion();
    $display("motion test done");
    t_laser();
    $display("laser test done");
    t_stats();
    $display("stats test done");
    t_dump();
    $display("dump test done");
    results();
  end
  initial begin
    repeat (100000) @(posedge mclk);
    bad_count++;
    results();
  end
endmodule
